/* pboo_cfg.svh */
`ifndef PBOO_CFG_SVH
`define PBOO_CFG_SVH

// Clock rate and the length of one timebase tick.
`define PBOO_CLK_HZ 20000000
`define PBOO_TICK_MS 1
`define PBOO_MS_CYC ((`PBOO_CLK_HZ / 1000) * `PBOO_TICK_MS)

// Intervals in milliseconds.
`define PBOO_ON_DB_MS 32
`define PBOO_OFF_DB_MS 32
`define PBOO_REL_DB_MS 32
`define PBOO_BLANK_MS 512
`define PBOO_SHUT_MS 1024
`define PBOO_LOCK_MS 256

// Shortest power-cut low that is acted upon, rounded up to whole cycles.
`define PBOO_KILL_PW_US 30
`define PBOO_KILL_CYC ((`PBOO_KILL_PW_US * (`PBOO_CLK_HZ / 1000) + 999) / 1000)

// Counter widths.
`define PBOO_MS_W 17
`define PBOO_DIV_W 15
`define PBOO_KCNT_W 10
`define PBOO_EXT_W 16

`endif

/* pboo_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Processor model on the far side
// ----------------------------------------
// The power-cut line is low while the processor is unpowered or still booting.
module pboo_host_model #(
  parameter int BOOT_CYC = 400,
  parameter int HK_CYC = 800
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic supply_en_i,
  input wire logic shutdown_req_n_i,
  input wire logic boot_ok_i,
  input wire logic ack_i,
  input wire logic cut_i,
  output logic kill_n_o
);
  logic [1:0] phase;
  logic [15:0] cnt;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i || !supply_en_i) begin
      phase <= 2'h0;
      cnt <= 16'h0;
    end else if (phase == 2'h0 && boot_ok_i) begin
      cnt <= cnt + 16'h1;
      if (cnt == 16'(BOOT_CYC)) phase <= 2'h1;
    end else if (phase == 2'h1 && !shutdown_req_n_i && ack_i) begin
      cnt <= cnt + 16'h1;
      if (cnt == 16'(BOOT_CYC + HK_CYC)) phase <= 2'h2;
    end
  end

  assign kill_n_o = (phase == 2'h1) && !cut_i;
endmodule // pboo_host_model

/* pboo_pkg.sv */
`include "pboo_cfg.svh"

package pboo_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ON_DB,
    S_BLANK,
    S_ON_REL,
    S_RUN,
    S_OFF_DB,
    S_SHUT,
    S_LOCK,
    S_OFF_REL
  } pboo_state_t;

  typedef struct packed {
    pboo_state_t state;
    logic [2:0] pb_sync;
    logic [2:0] kill_sync;
    logic pb_lvl;
    logic pb_prev;
    logic kill_lvl;
    logic [`PBOO_KCNT_W-1:0] kill_cnt;
    logic kill_act;
    logic [`PBOO_DIV_W-1:0] div_cnt;
    logic tick;
    logic [`PBOO_MS_W-1:0] ms_cnt;
    logic on;
    logic en_pin;
    logic int_n;
  } pboo_regs_t;

endpackage

/* pboo_sequencer.sv */
`timescale 1ns/10ps
`include "pboo_cfg.svh"

module pboo_sequencer import pboo_pkg::*; #(
  parameter bit EN_ACTIVE_HIGH = 1'b1,
  parameter int unsigned MS_CYCLES = `PBOO_MS_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pushbutton_n_i,
  input wire logic kill_n_i,
  input wire logic [`PBOO_EXT_W-1:0] on_time_extend_i,
  input wire logic [`PBOO_EXT_W-1:0] off_time_extend_i,
  output logic supply_en_o,
  output logic shutdown_req_n_o
);

  // Enable pin levels; the two build variants differ only here.
  localparam logic EN_ON = EN_ACTIVE_HIGH;
  localparam logic EN_OFF = ~EN_ACTIVE_HIGH;
  localparam logic [`PBOO_DIV_W-1:0] DIV_LAST = `PBOO_DIV_W'(MS_CYCLES - 1);
  localparam logic [`PBOO_KCNT_W-1:0] KILL_CYC = `PBOO_KCNT_W'(`PBOO_KILL_CYC);
  // Interval limits, counted in timebase ticks.
  localparam logic [`PBOO_MS_W-1:0] BLANK_MS = `PBOO_MS_W'(`PBOO_BLANK_MS);
  localparam logic [`PBOO_MS_W-1:0] SHUT_MS = `PBOO_MS_W'(`PBOO_SHUT_MS);
  localparam logic [`PBOO_MS_W-1:0] LOCK_MS = `PBOO_MS_W'(`PBOO_LOCK_MS);
  localparam logic [`PBOO_MS_W-1:0] REL_MS = `PBOO_MS_W'(`PBOO_REL_DB_MS);

  pboo_regs_t st;
  pboo_regs_t next_st;
  logic [`PBOO_MS_W-1:0] on_lim;
  logic [`PBOO_MS_W-1:0] off_lim;

  // The extension inputs give extra milliseconds on top of the fixed debounce.
  assign on_lim = `PBOO_MS_W'(`PBOO_ON_DB_MS) + `PBOO_MS_W'(on_time_extend_i);
  assign off_lim = `PBOO_MS_W'(`PBOO_OFF_DB_MS) + `PBOO_MS_W'(off_time_extend_i);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic restart;
    logic cut_off;
    restart = 1'b0;
    cut_off = 1'b0;
    next_st = st;
    next_st.pb_sync = {st.pb_sync[1:0], pushbutton_n_i};
    next_st.kill_sync = {st.kill_sync[1:0], kill_n_i};
    if (st.pb_sync[1] == st.pb_sync[2]) begin
      next_st.pb_lvl = st.pb_sync[2];
    end
    if (st.kill_sync[1] == st.kill_sync[2]) begin
      next_st.kill_lvl = st.kill_sync[2];
    end
    next_st.pb_prev = st.pb_lvl;
    // A power-cut low counts only once it has lasted the full pulse width.
    if (st.kill_lvl) begin
      next_st.kill_cnt = '0;
      next_st.kill_act = 1'b0;
    end else if (st.kill_cnt != KILL_CYC) begin
      next_st.kill_cnt = st.kill_cnt + 1'b1;
    end else begin
      next_st.kill_act = 1'b1;
    end
    // One millisecond timebase feeds every interval.
    next_st.tick = 1'b0;
    if (st.div_cnt == DIV_LAST) begin
      next_st.div_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 1'b1;
    end
    if (st.tick) begin
      next_st.ms_cnt = st.ms_cnt + 1'b1;
    end
    unique case (st.state)
      S_IDLE: begin
        if (st.pb_prev && !st.pb_lvl) begin
          next_st.state = S_ON_DB;
          restart = 1'b1;
        end
      end
      // Turn-on qualification; any release goes back to idle.
      S_ON_DB: begin
        if (st.pb_lvl) begin
          next_st.state = S_IDLE;
        end else if (st.ms_cnt >= on_lim) begin
          next_st.on = 1'b1;
          next_st.state = S_BLANK;
          restart = 1'b1;
        end
      end
      S_BLANK: begin
        // Neither input is looked at until the window has run out.
        if (st.ms_cnt >= BLANK_MS) begin
          restart = 1'b1;
          if (!st.kill_lvl) begin
            cut_off = 1'b1;
          end else begin
            next_st.state = S_ON_REL;
          end
        end
      end
      // Power is up; the button must stay released before run.
      S_ON_REL: begin
        if (st.kill_act) begin
          cut_off = 1'b1;
          restart = 1'b1;
        end else if (!st.pb_lvl) begin
          restart = 1'b1;
        end else if (st.ms_cnt >= REL_MS) begin
          next_st.state = S_RUN;
        end
      end
      S_RUN: begin
        if (st.kill_act) begin
          cut_off = 1'b1;
          restart = 1'b1;
        end else if (!st.pb_lvl) begin
          next_st.state = S_OFF_DB;
          restart = 1'b1;
        end
      end
      // Turn-off qualification; a release returns to run.
      S_OFF_DB: begin
        if (st.kill_act) begin
          cut_off = 1'b1;
          restart = 1'b1;
        end else if (st.pb_lvl) begin
          next_st.state = S_RUN;
        end else if (st.ms_cnt >= off_lim) begin
          next_st.int_n = 1'b0;
          next_st.state = S_SHUT;
          restart = 1'b1;
        end
      end
      // Housekeeping window; a power-cut ends it early.
      S_SHUT: begin
        if (st.kill_act) begin
          cut_off = 1'b1;
          restart = 1'b1;
        end else if (st.ms_cnt >= SHUT_MS) begin
          next_st.on = 1'b0;
          next_st.int_n = 1'b1;
          next_st.state = S_OFF_REL;
          restart = 1'b1;
        end
      end
      // Converter decay time; the pushbutton is not looked at.
      S_LOCK: begin
        if (st.ms_cnt >= LOCK_MS) begin
          next_st.state = S_OFF_REL;
          restart = 1'b1;
        end
      end
      // A held button must be let go before idle can rearm.
      S_OFF_REL: begin
        if (!st.pb_lvl) begin
          restart = 1'b1;
        end else if (st.ms_cnt >= REL_MS) begin
          next_st.state = S_IDLE;
        end
      end
    endcase
    // A power-cut always lands in lockout with the request released.
    if (cut_off) begin
      next_st.on = 1'b0;
      next_st.int_n = 1'b1;
      next_st.state = S_LOCK;
    end
    // Every state change that starts an interval clears the timebase.
    if (restart) begin
      next_st.div_cnt = '0;
      next_st.tick = 1'b0;
      next_st.ms_cnt = '0;
    end
    // The pin level is registered so that the output never glitches.
    next_st.en_pin = next_st.on ? EN_ON : EN_OFF;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.state <= S_IDLE;
      st.pb_sync <= 3'h7;
      st.kill_sync <= 3'h7;
      st.pb_lvl <= 1'b1;
      st.pb_prev <= 1'b1;
      st.kill_lvl <= 1'b1;
      st.on <= 1'b0;
      st.en_pin <= EN_OFF;
      st.int_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Both outputs come straight from the state register.
  assign supply_en_o = st.en_pin;
  assign shutdown_req_n_o = st.int_n;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_on_qualified: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(st.on) |-> $past(st.state) == S_ON_DB && $past(st.ms_cnt) >= $past(on_lim) && !$past(st.pb_lvl))
    else $error("enable asserted without a qualified press");
  a_blank_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(st.on) |-> st.state == S_BLANK && st.ms_cnt == '0)
    else $error("blanking did not start with enable");
  a_blank_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_BLANK && st.ms_cnt < BLANK_MS |=> st.on && st.int_n)
    else $error("enable changed inside blanking");
  a_abort_power: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_BLANK && st.ms_cnt >= BLANK_MS && !st.kill_lvl |=> !st.on ##1 supply_en_o == EN_OFF)
    else $error("power-on not aborted");
  a_int_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(st.int_n) |-> $past(st.state) == S_OFF_DB && $past(st.ms_cnt) >= $past(off_lim))
    else $error("shutdown request without qualified press");
  a_shut_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_SHUT |-> st.on && !st.int_n && st.ms_cnt <= SHUT_MS)
    else $error("shutdown window overran");
  a_kill_cut: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.kill_act && st.state inside {S_ON_REL, S_RUN, S_OFF_DB, S_SHUT} |=> !st.on && st.state == S_LOCK)
    else $error("power-cut did not drop enable");
  a_kill_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(st.kill_act) |-> $past(st.kill_cnt) == KILL_CYC && !$past(st.kill_lvl))
    else $error("short power-cut pulse accepted");
  a_lock_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_LOCK && st.ms_cnt < LOCK_MS |=> st.state == S_LOCK && !st.on)
    else $error("lockout left early");
  a_int_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !st.on |-> st.int_n)
    else $error("shutdown request held while off");
  a_en_polarity: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 supply_en_o == (st.on ? EN_ON : EN_OFF))
    else $error("enable pin level mismatches state");

  // Checks on the qualification, release, shutdown-window and timebase paths.
  a_off_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state inside {S_IDLE, S_ON_DB} |-> !st.on && supply_en_o == EN_OFF)
    else $error("enable active while powered down");
  a_on_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_ON_DB && st.pb_lvl |=> st.state == S_IDLE && !st.on)
    else $error("early release did not restart turn-on");
  a_on_ext_used: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_ON_DB && !st.pb_lvl && st.ms_cnt < on_lim |=> !st.on)
    else $error("enable asserted before extended turn-on time");
  a_rel_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_ON_REL && !st.pb_lvl && !st.kill_act |=> st.state == S_ON_REL && st.ms_cnt == '0)
    else $error("release debounce not restarted");
  a_off_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_OFF_DB && st.pb_lvl && !st.kill_act |=> st.state == S_RUN && st.int_n)
    else $error("early release did not restart turn-off");
  a_off_ext_used: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_OFF_DB && st.ms_cnt < off_lim |=> st.int_n)
    else $error("shutdown request before extended turn-off time");
  a_shut_expire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_SHUT && st.ms_cnt >= SHUT_MS && !st.kill_act |=> !st.on && st.int_n && st.state == S_OFF_REL)
    else $error("enable not dropped at end of shutdown window");
  a_idle_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_IDLE && !(st.pb_prev && !st.pb_lvl) |=> st.state == S_IDLE)
    else $error("idle left without a falling pushbutton edge");
  a_tick_source: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.tick |-> $past(st.div_cnt) == DIV_LAST)
    else $error("timebase tick not from the divider");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  c_power_on: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_ON_REL ##1 st.state == S_RUN);
  c_abort: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_BLANK ##1 st.state == S_LOCK);
  c_shut_kill: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_SHUT && st.kill_act);
  c_shut_timeout: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_SHUT ##1 st.state == S_OFF_REL);
  c_lockout_done: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == S_LOCK ##1 st.state == S_OFF_REL);

endmodule // pboo_sequencer

/* tb.sv */
`timescale 1ns/10ps
`include "pboo_cfg.svh"
module tb;
  localparam int MS = 4;
  localparam int TON = (32 + 8) * MS;
  localparam int TOFF = (32 + 4) * MS;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pb_n = 1'b1;
  logic boot_ok = 1'b0;
  logic ack = 1'b0;
  logic cut = 1'b0;
  logic [`PBOO_EXT_W-1:0] on_ext = 16'h0008;
  logic [`PBOO_EXT_W-1:0] off_ext = 16'h0004;
  logic en, req_n, en2, req2_n, kill_n;
  int num_errors = 0;
  int tests_run = 0;

  always #25 clk_i = ~clk_i;

  pboo_sequencer #(.EN_ACTIVE_HIGH(1'b1), .MS_CYCLES(MS)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .pushbutton_n_i(pb_n), .kill_n_i(kill_n), .on_time_extend_i(on_ext), .off_time_extend_i(off_ext),
    .supply_en_o(en), .shutdown_req_n_o(req_n));
  pboo_sequencer #(.EN_ACTIVE_HIGH(1'b0), .MS_CYCLES(MS)) dut_inv (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .pushbutton_n_i(pb_n), .kill_n_i(kill_n), .on_time_extend_i(on_ext), .off_time_extend_i(off_ext),
    .supply_en_o(en2), .shutdown_req_n_o(req2_n));
  pboo_host_model #(.BOOT_CYC(400), .HK_CYC(800)) host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .supply_en_i(en), .shutdown_req_n_i(req_n), .boot_ok_i(boot_ok), .ack_i(ack), .cut_i(cut),
    .kill_n_o(kill_n));

  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    num_errors++;
    $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic sig(input bit s);
    return s ? req_n : en;
  endfunction

  // Counts cycles until the output reaches v; it must not arrive before lo or after hi.
  task automatic wait_sig(input bit s, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    tests_run++;
    while (sig(s) !== v && n <= hi) begin
      @(negedge clk_i);
      n++;
    end
    if (n > hi) begin
      fail(n, hi);
      end_of_test();
    end else if (n < lo) begin
      fail(n, lo);
    end
  endtask

  task automatic hold(input bit s, input logic v, input int cyc);
    tests_run++;
    repeat (cyc) begin
      @(negedge clk_i);
      if (sig(s) !== v) fail({31'h0, sig(s)}, {31'h0, v});
    end
  endtask

  task automatic push();
    @(posedge clk_i);
    pb_n <= 1'b0;
  endtask

  task automatic rel();
    @(posedge clk_i);
    pb_n <= 1'b1;
  endtask

  task automatic power_on();
    push();
    wait_sig(0, 1'b1, TON - 3, TON + 12);
    rel();
    repeat (552 * MS) @(negedge clk_i);
  endtask

  task automatic t_abort();
    hold(0, 1'b0, 8);
    hold(1, 1'b1, 8);
    push();
    hold(0, 1'b0, 20 * MS);
    rel();
    hold(0, 1'b0, 8 * MS);
    push();
    wait_sig(0, 1'b1, TON - 3, TON + 12);
    wait_sig(0, 1'b0, 2044, 2064);
    rel();
    repeat (300 * MS) @(negedge clk_i);
  endtask

  task automatic t_timeout();
    boot_ok <= 1'b1;
    power_on();
    push();
    hold(1, 1'b1, 20 * MS);
    rel();
    hold(1, 1'b1, 8 * MS);
    push();
    wait_sig(1, 1'b0, TOFF - 3, TOFF + 12);
    rel();
    wait_sig(0, 1'b0, 4092, 4112);
    if (req_n !== 1'b1) fail({31'h0, req_n}, 32'h1);
    repeat (40 * MS) @(negedge clk_i);
  endtask

  task automatic t_ack();
    ack <= 1'b1;
    power_on();
    push();
    wait_sig(1, 1'b0, TOFF - 3, TOFF + 12);
    rel();
    wait_sig(0, 1'b0, 1396, 1424);
    if (req_n !== 1'b1) fail({31'h0, req_n}, 32'h1);
    hold(0, 1'b0, 100 * MS);
    push();
    hold(0, 1'b0, 50 * MS);
    rel();
    repeat (200 * MS) @(negedge clk_i);
  endtask

  task automatic t_cut();
    power_on();
    @(posedge clk_i);
    cut <= 1'b1;
    repeat (300) @(posedge clk_i);
    cut <= 1'b0;
    hold(0, 1'b1, 64);
    @(posedge clk_i);
    cut <= 1'b1;
    wait_sig(0, 1'b0, 598, 616);
    @(posedge clk_i);
    cut <= 1'b0;
    repeat (40 * MS) @(negedge clk_i);
  endtask

  // Both polarity variants must behave identically apart from the enable level.
  always @(negedge clk_i) begin
    if (!sys_rst_i && {en2, req2_n} !== {~en, req_n}) fail({30'h0, en2, req2_n}, {30'h0, ~en, req_n});
  end

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_abort();
    t_timeout();
    t_ack();
    t_cut();
    end_of_test();
  end
endmodule // tb
